// file: verilog/dspt_top.sv
// dual-slope pwm timer with axi4-lite register access
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dspt_top
  import dspt_pkg::*;
#(
  parameter int unsigned ADDR_W = 5
)
(
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_AXI_AWVALID,
  output logic O_AXI_AWREADY,
  input wire logic [ADDR_W-1:0] I_AXI_AWADDR,
  input wire logic [2:0] I_AXI_AWPROT,
  input wire logic I_AXI_WVALID,
  output logic O_AXI_WREADY,
  input wire logic [31:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  output logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  output logic [1:0] O_AXI_BRESP,
  input wire logic I_AXI_ARVALID,
  output logic O_AXI_ARREADY,
  input wire logic [ADDR_W-1:0] I_AXI_ARADDR,
  input wire logic [2:0] I_AXI_ARPROT,
  output logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  output logic [31:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP,
  output logic O_WAVE_A,
  output logic O_WAVE_A_OE,
  output logic O_WAVE_B,
  output logic O_WAVE_B_OE
);
  dspt_cnt_if cnt_if ();

  logic [31:0] ctrl_q;
  logic [15:0] cmpa_buf_q;
  logic [15:0] cmpb_buf_q;
  logic [15:0] captop_q;
  logic [1:0] pindir_q;
  logic aw_full_q;
  logic w_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic do_write;
  logic [9:0] psc_q;
  logic [15:0] count_q;
  logic [15:0] top_q;
  logic up_q;
  logic tick;
  logic at_top;
  logic at_bottom;
  logic reload;
  logic [15:0] top_src;
  logic cnt_write;
  logic [3:0] mode;
  dspt_kind_t kind;
  logic [1:0] com_a;
  logic [1:0] com_b;
  logic [2:0] cs;
  logic wave_a;
  logic wave_b;
  logic [15:0] active_a;
  logic [15:0] active_b;
  logic pin_a_q;
  logic pin_b_q;
  logic pin_a_oe_q;
  logic pin_b_oe_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = data[i*8 +: 8];
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = (a == REG_CTRL) || (a == REG_CMPA) || (a == REG_CMPB) || (a == REG_CAPTOP) ||
          (a == REG_COUNT) || (a == REG_STATUS) || (a == REG_PINDIR);
    return hit;
  endfunction

  // prescaler terminal count minus one; select zero stops the timer
  function automatic logic [9:0] div_m1(input logic [2:0] sel);
    logic [9:0] d;
    case (sel)
      3'h1: d = DIV1_M1;
      3'h2: d = DIV8_M1;
      3'h3: d = DIV64_M1;
      3'h4: d = DIV256_M1;
      3'h5: d = DIV1024_M1;
      default: d = DIV1_M1;
    endcase
    return d;
  endfunction

  assign mode = ctrl_q[CTRL_MODE_LSB +: 4];
  assign com_a = ctrl_q[CTRL_COMA_LSB +: 2];
  assign com_b = ctrl_q[CTRL_COMB_LSB +: 2];
  assign cs = ctrl_q[CTRL_CS_LSB +: 3];

  // write path: address and data may arrive in either order
  assign O_AXI_AWREADY = !aw_full_q;
  assign O_AXI_WREADY = !w_full_q;
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign cnt_write = do_write && (aw_addr_q == REG_COUNT);

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end
    else if (I_AXI_AWVALID && !aw_full_q)
    begin
      aw_full_q <= 1'b1;
      aw_addr_q <= I_AXI_AWADDR;
    end
    else if (do_write)
      aw_full_q <= 1'b0;
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else if (I_AXI_WVALID && !w_full_q)
    begin
      w_full_q <= 1'b1;
      w_data_q <= I_AXI_WDATA;
      w_strb_q <= I_AXI_WSTRB;
    end
    else if (do_write)
      w_full_q <= 1'b0;
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (I_AXI_BREADY)
      bvalid_q <= 1'b0;
  end

  // status and count are read-only apart from the count preset
  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      ctrl_q <= CTRL_RESET;
      cmpa_buf_q <= CMP_RESET;
      cmpb_buf_q <= CMP_RESET;
      captop_q <= CAPTOP_RESET;
      pindir_q <= 2'h0;
    end
    else if (do_write)
    begin
      case (aw_addr_q)
        REG_CTRL: ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q) & 32'h0000_07FF;
        REG_CMPA: cmpa_buf_q <= 16'(merge({16'h0000, cmpa_buf_q}, w_data_q, w_strb_q));
        REG_CMPB: cmpb_buf_q <= 16'(merge({16'h0000, cmpb_buf_q}, w_data_q, w_strb_q));
        REG_CAPTOP: captop_q <= 16'(merge({16'h0000, captop_q}, w_data_q, w_strb_q));
        REG_PINDIR: pindir_q <= 2'(merge({30'h0, pindir_q}, w_data_q, w_strb_q));
        default: ;
      endcase
    end
  end

  assign O_AXI_ARREADY = !rvalid_q;

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else if (I_AXI_ARVALID && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= mapped(I_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      case (I_AXI_ARADDR)
        REG_CTRL: rdata_q <= ctrl_q;
        REG_CMPA: rdata_q <= {16'h0000, cmpa_buf_q};
        REG_CMPB: rdata_q <= {16'h0000, cmpb_buf_q};
        REG_CAPTOP: rdata_q <= {16'h0000, captop_q};
        REG_COUNT: rdata_q <= {16'h0000, count_q};
        REG_STATUS: rdata_q <= {top_q, 15'h0000, up_q};
        REG_PINDIR: rdata_q <= {30'h0, pindir_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
    else if (I_AXI_RREADY)
      rvalid_q <= 1'b0;
  end

  // mode decode; unlisted modes leave the counter frozen
  always_comb
  begin
    kind = DSPT_STOP;
    top_src = TOP_8BIT;
    case (mode)
      MODE_PC8: kind = DSPT_PC;
      MODE_PC9:
      begin
        kind = DSPT_PC;
        top_src = TOP_9BIT;
      end
      MODE_PC10:
      begin
        kind = DSPT_PC;
        top_src = TOP_10BIT;
      end
      MODE_PC_CAP:
      begin
        kind = DSPT_PC;
        top_src = captop_q;
      end
      MODE_PC_CMPA:
      begin
        kind = DSPT_PC;
        top_src = cmpa_buf_q;
      end
      MODE_PFC_CAP:
      begin
        kind = DSPT_PFC;
        top_src = captop_q;
      end
      MODE_PFC_CMPA:
      begin
        kind = DSPT_PFC;
        top_src = cmpa_buf_q;
      end
      default: kind = DSPT_STOP;
    endcase
    // in frequency correct mode a top below 3 would collapse the dual slope, so it is raised
    if (kind == DSPT_PFC && top_src < TOP_MIN)
      top_src = TOP_MIN;
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
      psc_q <= 10'h000;
    else if (cs == 3'h0 || psc_q >= div_m1(cs))
      psc_q <= 10'h000;
    else
      psc_q <= psc_q + 10'h001;
  end

  assign tick = (cs != 3'h0) && (cs <= 3'h5) && (psc_q >= div_m1(cs)) &&
                (kind != DSPT_STOP);
  assign at_top = count_q >= top_q;
  assign at_bottom = count_q == BOTTOM;
  // reload point picks when top and compare buffers take effect
  assign reload = tick && ((kind == DSPT_PFC) ? at_bottom : (at_top && up_q));

  // top is only sampled at the reload point, so a change in phase correct
  // mode bends the next slope only and the period comes out uneven
  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
      top_q <= TOP_8BIT;
    else if (reload)
      top_q <= top_src;
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      count_q <= BOTTOM;
      up_q <= 1'b1;
    end
    else if (cnt_write)
      count_q <= 16'(merge({16'h0000, count_q}, w_data_q, w_strb_q));
    else if (tick)
    begin
      if (up_q && at_top)
      begin
        up_q <= 1'b0;
        count_q <= (count_q == BOTTOM) ? BOTTOM : count_q - 16'h0001;
      end
      else if (!up_q && at_bottom)
      begin
        up_q <= 1'b1;
        count_q <= count_q + 16'h0001;
      end
      else if (up_q)
        count_q <= count_q + 16'h0001;
      else
        count_q <= count_q - 16'h0001;
    end
  end

  assign cnt_if.count = count_q;
  assign cnt_if.top = top_q;
  assign cnt_if.up = up_q;
  assign cnt_if.tick = tick;
  assign cnt_if.reload = reload;

  dspt_cmp_unit u_cmp_a (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .cnt(cnt_if),
    .i_com(com_a),
    .i_buf(cmpa_buf_q),
    .i_toggle_ok(mode == MODE_PC_CMPA),
    .o_wave(wave_a),
    .o_active(active_a)
  );

  dspt_cmp_unit u_cmp_b (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .cnt(cnt_if),
    .i_com(com_b),
    .i_buf(cmpb_buf_q),
    .i_toggle_ok(1'b0),
    .o_wave(wave_b),
    .o_active(active_b)
  );

  // pin drives only with an output mode and direction set to output
  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
      pin_a_oe_q <= 1'b0;
      pin_b_oe_q <= 1'b0;
    end
    else
    begin
      pin_a_oe_q <= pindir_q[0] && (com_a != COM_OFF);
      pin_b_oe_q <= pindir_q[1] && (com_b != COM_OFF);
      pin_a_q <= pindir_q[0] && (com_a != COM_OFF) && wave_a;
      pin_b_q <= pindir_q[1] && (com_b != COM_OFF) && wave_b;
    end
  end

  assign O_WAVE_A = pin_a_q;
  assign O_WAVE_A_OE = pin_a_oe_q;
  assign O_WAVE_B = pin_b_q;
  assign O_WAVE_B_OE = pin_b_oe_q;
  assign O_AXI_BVALID = bvalid_q;
  assign O_AXI_BRESP = bresp_q;
  assign O_AXI_RVALID = rvalid_q;
  assign O_AXI_RDATA = rdata_q;
  assign O_AXI_RRESP = rresp_q;
endmodule
`default_nettype wire

// file: verilog/dspt_pkg.sv
// constants, types and register map of the dual-slope pwm timer
// Contract
// - phase correct: falling slope uses old top, rising slope uses new top.
// - phase correct: output mode two is non-inverted, three is inverted pwm.
// - waveform reaches the pin only while its direction bit selects output.
// - phase correct: one action on up-count match, the opposite on down-count.
// - prescaler divides by 1, 8, 64, 256 or 1024; period 2*N*TOP.
// - compare at bottom holds output low, at top holds high; inverted opposite.
// - mode 11 with compare a output mode one toggles output a, 50% duty.
// - modes 8 and 9 select phase and frequency correct dual-slope pwm.
// - counter runs from bottom 0x0000 up to top, then back down.
// - freq correct non-inverting clears on up match, sets on down match.
// - active compare values load from buffers; modes differ in load moment.
// - freq correct top comes from capture or compare a; minimum top 0x0003.
`default_nettype none
package dspt_pkg;
  localparam int unsigned CNT_W = 16;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_CMPA = 5'h04;
  localparam logic [4:0] REG_CMPB = 5'h08;
  localparam logic [4:0] REG_CAPTOP = 5'h0C;
  localparam logic [4:0] REG_COUNT = 5'h10;
  localparam logic [4:0] REG_STATUS = 5'h14;
  localparam logic [4:0] REG_PINDIR = 5'h18;
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_COMA_LSB = 4;
  localparam int unsigned CTRL_COMB_LSB = 6;
  localparam int unsigned CTRL_CS_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [15:0] CAPTOP_RESET = 16'h0000;
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_MIN = 16'h0003;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [3:0] MODE_PC8 = 4'h1;
  localparam logic [3:0] MODE_PC9 = 4'h2;
  localparam logic [3:0] MODE_PC10 = 4'h3;
  localparam logic [3:0] MODE_PFC_CAP = 4'h8;
  localparam logic [3:0] MODE_PFC_CMPA = 4'h9;
  localparam logic [3:0] MODE_PC_CAP = 4'hA;
  localparam logic [3:0] MODE_PC_CMPA = 4'hB;
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_NONINV = 2'h2;
  localparam logic [1:0] COM_INV = 2'h3;
  localparam logic [9:0] DIV1_M1 = 10'h000;
  localparam logic [9:0] DIV8_M1 = 10'h007;
  localparam logic [9:0] DIV64_M1 = 10'h03F;
  localparam logic [9:0] DIV256_M1 = 10'h0FF;
  localparam logic [9:0] DIV1024_M1 = 10'h3FF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {DSPT_STOP, DSPT_PC, DSPT_PFC} dspt_kind_t;
endpackage
`default_nettype wire

// file: verilog/dspt_cnt_if.sv
// counter state shared from the timer core to its compare units
`timescale 1ns/1ps
`default_nettype none
interface dspt_cnt_if;
  logic [15:0] count;
  logic [15:0] top;
  logic up;
  logic tick;
  logic reload;
  modport timer (output count, output top, output up, output tick, output reload);
  modport unit (input count, input top, input up, input tick, input reload);
endinterface
`default_nettype wire

// file: verilog/dspt_cmp_unit.sv
// one compare channel: buffered compare value and waveform register
`timescale 1ns/1ps
`default_nettype none
module dspt_cmp_unit
  import dspt_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  dspt_cnt_if.unit cnt,
  input wire logic [1:0] i_com,
  input wire logic [15:0] i_buf,
  input wire logic i_toggle_ok,
  output logic o_wave,
  output logic [15:0] o_active
);
  logic [15:0] active_q;
  logic wave_q;
  logic wave_d;
  logic match;
  logic non_inv;

  // active value follows the buffer only at the reload point
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      active_q <= CMP_RESET;
    else if (cnt.reload)
      active_q <= i_buf;
  end

  assign match = cnt.tick && (cnt.count == active_q);

  always_comb
  begin
    // inverted modes store the complement, so undo it before deciding
    non_inv = (i_com == COM_INV) ? !wave_q : wave_q;
    wave_d = wave_q;
    if (active_q >= cnt.top)
      non_inv = 1'b1;
    else if (active_q == BOTTOM)
      non_inv = 1'b0;
    else if (match)
      non_inv = !cnt.up;
    case (i_com)
      COM_NONINV: if (cnt.tick) wave_d = non_inv;
      COM_INV: if (cnt.tick) wave_d = !non_inv;
      COM_TOGGLE: if (match && i_toggle_ok) wave_d = !wave_q;
      default: wave_d = wave_q;
    endcase
  end

  // waveform keeps running even while the pin is an input
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      wave_q <= 1'b0;
    else
      wave_q <= wave_d;
  end

  assign o_wave = wave_q;
  assign o_active = active_q;
endmodule
`default_nettype wire

// file: bench/dspt_pin_load.sv
// load on one pwm pin: measures high and low run lengths
`timescale 1ns/1ps
`default_nettype none
module dspt_pin_load
(
  input wire logic i_clk,
  input wire logic i_pin,
  input wire logic i_oe,
  output int o_hi,
  output int o_lo,
  output int o_edges,
  output logic o_lvl
);
  int run;
  logic prev = 1'b0;
  // pull-down on the driver input, so an undriven pin reads low
  assign o_lvl = i_oe ? i_pin : 1'b0;
  always @(posedge i_clk)
  begin
    if (o_lvl != prev)
    begin
      if (prev)
        o_hi <= run;
      else
        o_lo <= run;
      o_edges <= o_edges + 1;
      run <= 1;
    end
    else
      run <= run + 1;
    prev <= o_lvl;
  end
endmodule
`default_nettype wire

// file: bench/dspt_top_assertions.sv
// concurrent checks on the pwm pins of the timer
`timescale 1ns/1ps
`default_nettype none
module dspt_top_assertions
(
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic O_AXI_BVALID,
  input wire logic O_WAVE_A,
  input wire logic O_WAVE_A_OE,
  input wire logic O_WAVE_B,
  input wire logic O_WAVE_B_OE
);
  default clocking dspt_cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);
  a_pin_gate_a: assert property (!O_WAVE_A_OE |-> !O_WAVE_A)
    else $error("pin a high while not driven");
  a_pin_gate_b: assert property (!O_WAVE_B_OE |-> !O_WAVE_B)
    else $error("pin b high while not driven");
  // enables only move one cycle after a register write lands
  a_oe_wr_a: assert property ($changed(O_WAVE_A_OE) |-> $past(O_AXI_BVALID))
    else $error("pin a enable moved without a write");
  a_oe_wr_b: assert property ($changed(O_WAVE_B_OE) |-> $past(O_AXI_BVALID))
    else $error("pin b enable moved without a write");
  // paired up and down matches never give a one-cycle pulse
  a_hi_pulse_a: assert property ($rose(O_WAVE_A) |=> O_WAVE_A)
    else $error("pin a high pulse too short");
  a_lo_pulse_a: assert property ($fell(O_WAVE_A) |=> !O_WAVE_A)
    else $error("pin a low pulse too short");
  a_hi_pulse_b: assert property ($rose(O_WAVE_B) |=> O_WAVE_B)
    else $error("pin b high pulse too short");
  a_lo_pulse_b: assert property ($fell(O_WAVE_B) |=> !O_WAVE_B)
    else $error("pin b low pulse too short");
endmodule
bind dspt_top dspt_top_assertions dspt_top_assertions_inst (.I_MCLK(I_MCLK), .I_RST(I_RST),
  .O_AXI_BVALID(O_AXI_BVALID), .O_WAVE_A(O_WAVE_A), .O_WAVE_A_OE(O_WAVE_A_OE),
  .O_WAVE_B(O_WAVE_B), .O_WAVE_B_OE(O_WAVE_B_OE));
`default_nettype wire

// file: bench/dspt_top_tb.sv
// self-checking bench of the dual-slope pwm timer
`timescale 1ns/1ps
`default_nettype none
module dspt_top_tb import dspt_pkg::*;;
  logic clk, rst, awv, wv, brdy, arv, rrdy;
  logic [4:0] awa, ara;
  logic [31:0] wdat, rdat, d;
  logic [1:0] bresp, rresp, r;
  logic awr, wrdy, bv, arr, rv, wa, wa_oe, wb, wb_oe, lva, lvb;
  int error_cnt, samples_checked, cyc, hia, loa, eda, hib, lob, edb;
  dspt_top dspt_top_inst (.I_MCLK(clk), .I_RST(rst), .I_AXI_AWVALID(awv),
    .O_AXI_AWREADY(awr), .I_AXI_AWADDR(awa), .I_AXI_AWPROT(3'h0), .I_AXI_WVALID(wv),
    .O_AXI_WREADY(wrdy), .I_AXI_WDATA(wdat), .I_AXI_WSTRB(4'hF), .O_AXI_BVALID(bv),
    .I_AXI_BREADY(brdy), .O_AXI_BRESP(bresp), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr),
    .I_AXI_ARADDR(ara), .I_AXI_ARPROT(3'h0), .O_AXI_RVALID(rv), .I_AXI_RREADY(rrdy),
    .O_AXI_RDATA(rdat), .O_AXI_RRESP(rresp), .O_WAVE_A(wa), .O_WAVE_A_OE(wa_oe),
    .O_WAVE_B(wb), .O_WAVE_B_OE(wb_oe));
  dspt_pin_load dspt_pin_load_inst (.i_clk(clk), .i_pin(wa), .i_oe(wa_oe), .o_hi(hia),
    .o_lo(loa), .o_edges(eda), .o_lvl(lva));
  dspt_pin_load dspt_pin_load_b_inst (.i_clk(clk), .i_pin(wb), .i_oe(wb_oe), .o_hi(hib),
    .o_lo(lob), .o_edges(edb), .o_lvl(lvb));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] ctl(logic [3:0] m, logic [1:0] ca, logic [1:0] cb,
    logic [2:0] cs);
    return {21'h0, cs, cb, ca, m};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // both channels offered together; each released at its own handshake
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wdat <= v;
    brdy <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awr)
        awv <= 1'b0;
      if (wrdy)
        wv <= 1'b0;
    end
    while (awv || wv);
    do
      @(posedge clk);
    while (!bv);
    r = bresp;
  endtask
  task automatic rd(input logic [4:0] a);
    arv <= 1'b1;
    ara <= a;
    rrdy <= 1'b1;
    do
      @(posedge clk);
    while (!arr);
    arv <= 1'b0;
    do
      @(posedge clk);
    while (!rv);
    d = rdat;
    r = rresp;
  endtask
  task automatic rst_dut;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_regs;
    rd(REG_STATUS);
    chk("status", {TOP_8BIT, 16'h0001}, d);
    rd(REG_COUNT);
    chk("count", {16'h0, BOTTOM}, d);
    rd(5'h1C);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
    wr(5'h1C, 32'h0);
    chk("unmapped wr resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(REG_CMPB, 32'hFFFF_1234);
    rd(REG_CMPB);
    chk("cmp b readback", 32'h0000_1234, d);
    $display("test registers done");
  endtask
  task automatic t_pc;
    logic [1:0] com;
    logic [15:0] cm [3];
    int e;
    cm = '{16'h0040, BOTTOM, TOP_8BIT};
    for (int j = 0; j < 2; j++)
    begin
      com = j ? COM_INV : COM_NONINV;
      rst_dut();
      wr(REG_CTRL, ctl(MODE_PC8, com, COM_OFF, 3'h1));
      chk("oe a", 32'h0, {31'h0, wa_oe});
      chk("pin a", 32'h0, {31'h0, wa});
      wr(REG_PINDIR, 32'h1);
      for (int k = 0; k < 3; k++)
      begin
        wr(REG_CMPA, {16'h0, cm[k]});
        repeat (1100) @(posedge clk);
        e = eda;
        repeat (520) @(posedge clk);
        if (k == 0)
        begin
          chk("high a", j ? 382 : 128, hia);
          chk("period a", 510, hia + loa);
        end
        else
        begin
          chk("edges a", e, eda);
          chk("level a", {31'h0, (cm[k] == TOP_8BIT) ^ j[0]}, {31'h0, lva});
        end
      end
    end
    $display("test phase correct done");
  endtask
  task automatic t_tog;
    rst_dut();
    wr(REG_PINDIR, 32'h1);
    wr(REG_CMPA, 32'h10);
    wr(REG_CTRL, ctl(MODE_PC_CMPA, COM_TOGGLE, COM_OFF, 3'h1));
    repeat (1200) @(posedge clk);
    chk("toggle high", 32, hia);
    chk("toggle low", 32, loa);
    $display("test toggle done");
  endtask
  // top from compare a, loaded at bottom
  task automatic t_pfc;
    rst_dut();
    wr(REG_PINDIR, 32'h2);
    wr(REG_CMPA, 32'h10);
    wr(REG_CMPB, 32'h4);
    wr(REG_CTRL, ctl(MODE_PFC_CMPA, COM_OFF, COM_NONINV, 3'h1));
    repeat (1200) @(posedge clk);
    chk("pfc high", 8, hib);
    chk("pfc low", 24, lob);
    $display("test freq correct done");
  endtask
  // phase correct with capture top, then a smaller top while running
  task automatic t_pccap;
    rst_dut();
    wr(REG_PINDIR, 32'h2);
    wr(REG_CAPTOP, 32'h20);
    wr(REG_CMPB, 32'h8);
    wr(REG_CTRL, ctl(MODE_PC_CAP, COM_OFF, COM_NONINV, 3'h1));
    repeat (900) @(posedge clk);
    chk("pc cap high", 16, hib);
    chk("pc cap low", 48, lob);
    wr(REG_CAPTOP, 32'h10);
    repeat (300) @(posedge clk);
    chk("new top high", 16, hib);
    chk("new top low", 16, lob);
    $display("test capture top done");
  endtask
  // capture top below the minimum is raised to three
  task automatic t_presc;
    int dv [5];
    dv = '{1, 8, 64, 256, 1024};
    rst_dut();
    wr(REG_PINDIR, 32'h2);
    wr(REG_CAPTOP, 32'h1);
    wr(REG_CMPB, 32'h1);
    wr(REG_CTRL, ctl(MODE_PFC_CAP, COM_OFF, COM_NONINV, 3'h1));
    repeat (600) @(posedge clk);
    for (int i = 0; i < 5; i++)
    begin
      wr(REG_CTRL, ctl(MODE_PFC_CAP, COM_OFF, COM_NONINV, 3'(i + 1)));
      repeat (18 * dv[i] + 20) @(posedge clk);
      chk("div high", 2 * dv[i], hib);
      chk("div low", 4 * dv[i], lob);
    end
    $display("test prescaler done");
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // whole run needs about 40000 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 70000)
    begin
      error_cnt++;
      summarize();
    end
  end
  initial
  begin
    awv <= 1'b0;
    wv <= 1'b0;
    arv <= 1'b0;
    brdy <= 1'b0;
    rrdy <= 1'b0;
    awa <= 5'h00;
    ara <= 5'h00;
    wdat <= 32'h0000_0000;
    rst_dut();
    t_regs();
    t_pc();
    t_tog();
    t_pfc();
    t_pccap();
    t_presc();
    summarize();
  end
endmodule
`default_nettype wire
